// [core/phase_mode_fault_supervisor.sv]
// Phase-mode selection, glitch filtering and fault latching for a two-phase buck controller
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
// Function
// - Low-current input high keeps two phases unless sleep select and stop are both asserted
// - Low-current low: phase 1 only, phase 2 off
// - Mode decode from sleep, stop, low-current
// - Diode emulation: low side off at zero
// - No phase idling under two periods
// - No diode emulation under seven periods
// - Single-phase entry waits for voltage ramp
// - Code change in emulation returns two-phase
// - Start-up always runs two-phase
// - Slow slew when sleep select high
// - Overcurrent threshold halved in one-phase
// - Overcurrent latches after 120 us persistence
// - Double overcurrent shuts drive immediately
// - Two-phase imbalance for 1 ms latches
// - Undervoltage for 1 ms latches
// - Overvoltage 200 mV for 1 ms latches
// - Faults: good low, drives high impedance
// - Faults clear on enable low or supply
// - 1.7 V clamp low sides until 0.85 V
// - 1.7 V latch clears only on supply
// - Thermistor low drives throttle low only
// - Idle phase after its current reaches zero
// - Upstream supplies low latches off until enable
module phase_mode_fault_supervisor import supervisor_pkg::*; #(
	parameter int OC_CYCLES = OC_PERSIST_CYC,
	parameter int MS_CYCLES = FAULT_PERSIST_CYC
) (
	// Clock and supply reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power-management control
	input wire pm_ctl_s pm_ctl,
	input wire logic regulator_enable,
	input wire logic upstream_supplies_good,
	input wire logic [6:0] voltage_id_code,
	input wire logic vid_ramp_active,
	input wire logic softstart_done,
	input wire logic sw_period_tick,
	// Comparator flags
	input wire sense_s sense,
	// Drive and status outputs
	output drive_e phase1_drive,
	output drive_e phase2_drive,
	output logic phase1_low_off,
	output logic current_shift,
	output logic softstart_request,
	output logic output_good_flag,
	output logic slew_fast,
	output logic oc_half_threshold,
	output logic thermal_throttle_n
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [TIMER_W-1:0] persist(input logic [TIMER_W-1:0] cnt, input logic cond, input int lim);
		logic [TIMER_W-1:0] l;
		l = TIMER_W'(lim);
		if (!cond)
			persist = '0;
		else if (cnt >= l)
			persist = l;
		else
			persist = cnt + 1'b1;
	endfunction

	function automatic logic timer_done(input logic [TIMER_W-1:0] cnt, input int lim);
		timer_done = cnt >= TIMER_W'(lim);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	mode_state_e state_ff, nxt_state;
	mode_req_e req_ff;
	logic [3:0] persist_ff;
	logic [6:0] vid_ff;
	logic [3:0] fault_ff;
	logic pgd_latch_ff, ov17_ff, clamp_ff;
	logic [TIMER_W-1:0] oc_cnt_ff, imb_cnt_ff, uv_cnt_ff, ov_cnt_ff;
	logic [31:0] ctrl_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	drive_e p1_ff, p2_ff, nxt_p1, nxt_p2;
	logic p1_low_off_ff, shift_ff, ss_req_ff, good_ff, slew_ff, half_ff, tt_n_ff;

	// ----------------------------------------
	// Mode decode and glitch filtering
	// ----------------------------------------
	// Deep-sleep select with stop asserted wins over the low-current input
	wire dcm_combo = pm_ctl.deep_sleep_vr_select && !pm_ctl.deeper_stop_n;
	wire mode_req_e req_now = dcm_combo ? REQ_DCM :
		(pm_ctl.low_current_indication_n ? REQ_TWO : REQ_ONE);
	// Strictly greater: count of ticks over-reads a partial first period
	wire idle_ok = (req_ff != REQ_TWO) && (persist_ff > IDLE_MIN_PERIODS);
	wire dcm_ok = (req_ff == REQ_DCM) && (persist_ff > DCM_MIN_PERIODS);
	wire force_two = ctrl_ff[CTRL_FORCE_TWO_BIT];
	wire vid_changed = voltage_id_code != vid_ff;
	wire one_phase = (state_ff == ST_ONE_CCM) || (state_ff == ST_ONE_DCM);

	// Persistence counted in switching periods, restarted on any change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_ff <= REQ_TWO;
			persist_ff <= '0;
		end else begin
			req_ff <= req_now;
			if (req_now != req_ff)
				persist_ff <= '0;
			else if (sw_period_tick && persist_ff != PERSIST_SAT)
				persist_ff <= persist_ff + 1'b1;
		end
	end

	// ----------------------------------------
	// Fault detection
	// ----------------------------------------
	// Flags arrive already synchronous; timers run on pclk
	wire running = (state_ff != ST_OFF) && (state_ff != ST_SHUTDOWN);
	wire oc_set = running && timer_done(oc_cnt_ff, OC_CYCLES);
	wire way_oc = running && sense.oc_over_twice;
	wire imb_set = timer_done(imb_cnt_ff, MS_CYCLES);
	wire uv_set = running && timer_done(uv_cnt_ff, MS_CYCLES);
	wire ov_set = running && timer_done(ov_cnt_ff, MS_CYCLES);
	wire ov17_set = regulator_enable && sense.overvolt_1v7;
	wire pgd_set = running && (state_ff != ST_START) && !upstream_supplies_good;
	wire kill = (|fault_ff) || pgd_latch_ff || ov17_ff || way_oc || ov17_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_cnt_ff <= '0;
			imb_cnt_ff <= '0;
			uv_cnt_ff <= '0;
			ov_cnt_ff <= '0;
		end else begin
			oc_cnt_ff <= persist(oc_cnt_ff, running && sense.oc_over, OC_CYCLES);
			imb_cnt_ff <= persist(imb_cnt_ff, state_ff == ST_TWO_CCM && sense.imbalance, MS_CYCLES);
			uv_cnt_ff <= persist(uv_cnt_ff, running && sense.undervolt, MS_CYCLES);
			ov_cnt_ff <= persist(ov_cnt_ff, running && sense.overvolt_200, MS_CYCLES);
		end
	end

	// Enable-cleared latches; the 1.7 V latch survives enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= '0;
			pgd_latch_ff <= 1'b0;
			ov17_ff <= 1'b0;
			clamp_ff <= 1'b0;
		end else begin
			if (!regulator_enable) begin
				fault_ff <= '0;
				pgd_latch_ff <= 1'b0;
			end else begin
				fault_ff <= fault_ff | {ov_set, uv_set, imb_set, oc_set || way_oc};
				pgd_latch_ff <= pgd_latch_ff || pgd_set;
			end
			ov17_ff <= ov17_ff || ov17_set;
			// Rising above 1.7 V again wins over the release
			if (ov17_set)
				clamp_ff <= 1'b1;
			else if (sense.below_0v85)
				clamp_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		if (!regulator_enable)
			nxt_state = ST_OFF;
		else if (kill)
			nxt_state = ST_SHUTDOWN;
		else begin
			case (state_ff)
				ST_OFF: nxt_state = ST_START;
				// Control inputs are ignored until soft-start ends
				ST_START: if (softstart_done) nxt_state = ST_TWO_CCM;
				ST_TWO_CCM: begin
					if (idle_ok && !vid_ramp_active && !force_two)
						nxt_state = ST_SHED;
				end
				ST_SHED: begin
					if (req_ff == REQ_TWO || force_two)
						nxt_state = ST_TWO_CCM;
					else if (sense.phase2_zero)
						nxt_state = (dcm_ok && !vid_ramp_active) ? ST_ONE_DCM : ST_ONE_CCM;
				end
				ST_ONE_CCM: begin
					if (req_ff == REQ_TWO || force_two)
						nxt_state = ST_TWO_CCM;
					else if (dcm_ok && !vid_ramp_active)
						nxt_state = ST_ONE_DCM;
				end
				ST_ONE_DCM: begin
					if (vid_changed || req_ff != REQ_DCM || force_two)
						nxt_state = ST_TWO_CCM;
				end
				default: nxt_state = ST_SHUTDOWN;
			endcase
		end
	end

	// ----------------------------------------
	// Drive selection
	// ----------------------------------------
	// Clamp overrides every other action, including other faults
	always_comb begin
		nxt_p1 = DRV_HIZ;
		nxt_p2 = DRV_HIZ;
		if (ov17_ff || ov17_set) begin
			nxt_p1 = (clamp_ff || ov17_set) ? DRV_LOW_ON : DRV_HIZ;
			nxt_p2 = nxt_p1;
		end else if (!kill && regulator_enable) begin
			case (nxt_state)
				ST_START, ST_TWO_CCM, ST_SHED: begin
					nxt_p1 = DRV_CCM;
					nxt_p2 = DRV_CCM;
				end
				ST_ONE_CCM: nxt_p1 = DRV_CCM;
				ST_ONE_DCM: nxt_p1 = DRV_DCM;
				default: nxt_p1 = DRV_HIZ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_OFF;
			vid_ff <= '0;
			p1_ff <= DRV_HIZ;
			p2_ff <= DRV_HIZ;
		end else begin
			state_ff <= nxt_state;
			vid_ff <= voltage_id_code;
			p1_ff <= nxt_p1;
			p2_ff <= nxt_p2;
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	wire good_now = regulator_enable && !kill && (nxt_state != ST_START) && (nxt_state != ST_OFF);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_low_off_ff <= 1'b0;
			shift_ff <= 1'b0;
			ss_req_ff <= 1'b0;
			good_ff <= 1'b0;
			slew_ff <= 1'b0;
			half_ff <= 1'b0;
			tt_n_ff <= 1'b1;
		end else begin
			p1_low_off_ff <= (nxt_p1 == DRV_DCM) && sense.phase1_zero;
			shift_ff <= nxt_state == ST_SHED;
			ss_req_ff <= (state_ff == ST_OFF) && (nxt_state == ST_START);
			good_ff <= good_now;
			slew_ff <= !pm_ctl.deep_sleep_vr_select;
			half_ff <= (nxt_state == ST_ONE_CCM) || (nxt_state == ST_ONE_DCM);
			tt_n_ff <= !sense.thermistor_low;
		end
	end

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	wire setup = psel && !penable;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_status = paddr == ADDR_STATUS;
	wire hit_vid = paddr == ADDR_VID;
	wire mapped = hit_ctrl || hit_status || hit_vid;
	wire [31:0] status_word = {20'h0_0000, ov17_ff, clamp_ff, pgd_latch_ff, fault_ff, 2'h0, state_ff};
	wire [31:0] rd_word = hit_ctrl ? ctrl_ff :
		hit_status ? status_word :
		hit_vid ? {25'h000_0000, voltage_id_code} : ZERO_WORD;

	// Answer in the cycle after setup: one access cycle, no waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			prdata_ff <= ZERO_WORD;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			if (setup && !pwrite)
				prdata_ff <= rd_word;
			if (psel && penable && pready_ff && pwrite && hit_ctrl)
				ctrl_ff <= {31'h0000_0000, pwdata[CTRL_FORCE_TWO_BIT]};
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign phase1_drive = p1_ff;
	assign phase2_drive = p2_ff;
	assign phase1_low_off = p1_low_off_ff;
	assign current_shift = shift_ff;
	assign softstart_request = ss_req_ff;
	assign output_good_flag = good_ff;
	assign slew_fast = slew_ff;
	assign oc_half_threshold = half_ff;
	assign thermal_throttle_n = tt_n_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_WAY_OC_OFF: assert property (
		(state_ff inside {ST_TWO_CCM, ST_ONE_CCM}) && regulator_enable && sense.oc_over_twice
		|=> !output_good_flag && phase1_drive != DRV_CCM && phase2_drive != DRV_CCM)
		else $error("double overcurrent did not stop the drives");
	AST_START_TWO: assert property (
		state_ff == ST_START && !kill && regulator_enable |=> phase2_drive == DRV_CCM)
		else $error("start-up not two-phase");
	AST_ONE_IDLE_P2: assert property (
		state_ff == ST_ONE_CCM && !ov17_ff |-> phase2_drive == DRV_HIZ)
		else $error("phase 2 active in one-phase mode");
	AST_DCM_LOW_OFF: assert property (
		state_ff == ST_ONE_DCM && nxt_state == ST_ONE_DCM && sense.phase1_zero
		|=> phase1_low_off && phase1_drive == DRV_DCM)
		else $error("low side not released at zero current");
	AST_VID_EXIT: assert property (
		state_ff == ST_ONE_DCM && vid_changed && regulator_enable && !kill |=> state_ff == ST_TWO_CCM)
		else $error("code change did not leave emulation");
	AST_RAMP_HOLD: assert property (
		state_ff == ST_TWO_CCM && vid_ramp_active |=> state_ff != ST_SHED)
		else $error("phase shed during voltage ramp");
	AST_SHORT_GLITCH: assert property (
		$changed(req_ff) ##1 state_ff == ST_TWO_CCM [*2] |=> state_ff != ST_SHED)
		else $error("phase idled on a short control state");
	AST_OV17_STICKY: assert property (
		ov17_ff |=> ov17_ff && !output_good_flag)
		else $error("1.7 V latch lost");
	AST_FAULT_CLEAR: assert property (
		!regulator_enable |=> fault_ff == 4'h0 && !pgd_latch_ff)
		else $error("fault latch not cleared by enable");
	AST_HALF_OC: assert property (
		nxt_state inside {ST_ONE_CCM, ST_ONE_DCM} |=> oc_half_threshold)
		else $error("threshold not halved");
	AST_THROTTLE: assert property (
		sense.thermistor_low |=> !thermal_throttle_n)
		else $error("throttle not asserted");
	AST_SLEW: assert property (
		pm_ctl.deep_sleep_vr_select ##1 pm_ctl.deep_sleep_vr_select |-> !slew_fast)
		else $error("fast slew with sleep select high");

	COV_DCM: cover property (state_ff == ST_ONE_CCM ##1 state_ff == ST_ONE_DCM);
	COV_SHED: cover property (state_ff == ST_SHED ##1 state_ff == ST_ONE_CCM);
	COV_CLAMP: cover property (clamp_ff ##1 !clamp_ff);
	COV_SHUT: cover property (state_ff == ST_TWO_CCM ##1 state_ff == ST_SHUTDOWN);

endmodule

// [shared/supervisor_pkg.sv]
// Constants, states and carriers for the phase-mode and fault supervisor
package supervisor_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int OC_PERSIST_US = 120;
	localparam int OC_PERSIST_CYC = (OC_PERSIST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_PERSIST_MS = 1;
	localparam int FAULT_PERSIST_CYC = (FAULT_PERSIST_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 17;
	localparam logic [3:0] IDLE_MIN_PERIODS = 4'h2;
	localparam logic [3:0] DCM_MIN_PERIODS = 4'h7;
	localparam logic [3:0] PERSIST_SAT = 4'h8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_VID = 12'h008;
	localparam int CTRL_FORCE_TWO_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ----------------------------------------
	// Fault vector bit positions
	// ----------------------------------------
	localparam int FLT_OC = 0;
	localparam int FLT_IMB = 1;
	localparam int FLT_UV = 2;
	localparam int FLT_OV200 = 3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_START = 3'b001,
		ST_TWO_CCM = 3'b010,
		ST_SHED = 3'b011,
		ST_ONE_CCM = 3'b100,
		ST_ONE_DCM = 3'b101,
		ST_SHUTDOWN = 3'b110
	} mode_state_e;

	typedef enum logic [1:0] {
		DRV_HIZ = 2'b00,
		DRV_CCM = 2'b01,
		DRV_DCM = 2'b10,
		DRV_LOW_ON = 2'b11
	} drive_e;

	typedef enum logic [1:0] {
		REQ_TWO = 2'b00,
		REQ_ONE = 2'b01,
		REQ_DCM = 2'b10
	} mode_req_e;

	typedef struct packed {
		logic low_current_indication_n;
		logic deep_sleep_vr_select;
		logic deeper_stop_n;
	} pm_ctl_s;

	typedef struct packed {
		logic oc_over;
		logic oc_over_twice;
		logic imbalance;
		logic undervolt;
		logic overvolt_200;
		logic overvolt_1v7;
		logic below_0v85;
		logic phase1_zero;
		logic phase2_zero;
		logic thermistor_low;
	} sense_s;

endpackage

// [test/pm_side_model.sv]
// Processor-side model of the power-management control lines
`timescale 1ns/1ps
module pm_side_model import supervisor_pkg::*; (
	// Clock
	input wire logic pclk,
	// Control lines toward the supervisor
	output pm_ctl_s pm_ctl,
	output logic [6:0] voltage_id_code,
	output logic vid_ramp_active,
	output logic sw_period_tick
);
	// ----------------------------------------
	// Idle levels: active mode, no ramp
	// ----------------------------------------
	initial begin
		pm_ctl = '{1'h1, 1'h0, 1'h1};
		voltage_id_code = 7'h1c;
		vid_ramp_active = 1'h0;
		sw_period_tick = 1'h0;
	end

	// Levels change just after an edge, never between edges
	task automatic set_mode(input logic lci, input logic slp, input logic stp);
		@(posedge pclk);
		pm_ctl <= '{lci, slp, stp};
	endtask

	// One-cycle period pulses, spaced so none merge
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			sw_period_tick <= 1'h1;
			@(posedge pclk);
			sw_period_tick <= 1'h0;
			repeat (2) @(posedge pclk);
		end
	endtask

	// Code changes alone; the ramp flag is set by its own task
	task automatic set_vid(input logic [6:0] v);
		@(posedge pclk);
		voltage_id_code <= v;
	endtask

	task automatic set_ramp(input logic r);
		@(posedge pclk);
		vid_ramp_active <= r;
	endtask
endmodule

// [test/phase_mode_fault_supervisor_tb.sv]
// Self-checking bench for the phase-mode and fault supervisor
`timescale 1ns/1ps
module phase_mode_fault_supervisor_tb import supervisor_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, s;
	logic pready, pslverr, regulator_enable, upstream_supplies_good, softstart_done;
	pm_ctl_s pm_ctl;
	logic [6:0] voltage_id_code;
	logic vid_ramp_active, sw_period_tick;
	sense_s sense;
	drive_e phase1_drive, phase2_drive;
	logic phase1_low_off, current_shift, softstart_request, output_good_flag;
	logic slew_fast, oc_half_threshold, thermal_throttle_n;
	int checks = 0;
	int mismatches = 0;

	// ----------------------------------------
	// Clock, design and far side
	// ----------------------------------------
	initial pclk = 1'h0;
	always #4 pclk = ~pclk;

	// Short persistence counts keep the run brief
	phase_mode_fault_supervisor #(.OC_CYCLES(20), .MS_CYCLES(40)) i_phase_mode_fault_supervisor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pm_ctl(pm_ctl), .regulator_enable(regulator_enable), .upstream_supplies_good(upstream_supplies_good),
		.voltage_id_code(voltage_id_code), .vid_ramp_active(vid_ramp_active), .softstart_done(softstart_done),
		.sw_period_tick(sw_period_tick), .sense(sense), .phase1_drive(phase1_drive),
		.phase2_drive(phase2_drive), .phase1_low_off(phase1_low_off), .current_shift(current_shift),
		.softstart_request(softstart_request), .output_good_flag(output_good_flag), .slew_fast(slew_fast),
		.oc_half_threshold(oc_half_threshold), .thermal_throttle_n(thermal_throttle_n));

	pm_side_model i_pm_side_model (.pclk(pclk), .pm_ctl(pm_ctl), .voltage_id_code(voltage_id_code),
		.vid_ramp_active(vid_ramp_active), .sw_period_tick(sw_period_tick));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// One transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask

	task automatic st();
		logic e;
		apb(1'h0, ADDR_STATUS, 32'h0, s, e);
	endtask

	// Raise or drop one timed fault condition by index
	task automatic set_flt(input int k, input logic v);
		@(posedge pclk);
		case (k)
			0: sense.oc_over <= v;
			1: sense.imbalance <= v;
			2: sense.undervolt <= v;
			default: sense.overvolt_200 <= v;
		endcase
	endtask

	task automatic restart();
		@(posedge pclk) regulator_enable <= 1'h0;
		cyc(2);
		@(posedge pclk) regulator_enable <= 1'h1;
		cyc(4);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_start();
		// Idle bus, regulator enabled, start-up not yet done
		psel <= 1'h0;
		penable <= 1'h0;
		pwrite <= 1'h0;
		paddr <= ADDR_CTRL;
		pwdata <= ZERO_WORD;
		regulator_enable <= 1'h1;
		upstream_supplies_good <= 1'h1;
		softstart_done <= 1'h0;
		cyc(16);
		chk(phase1_drive, DRV_HIZ);
		chk(thermal_throttle_n, 1'h1);
		@(posedge pclk) presetn <= 1'h1;
		cyc(1);
		chk(softstart_request, 1'h1);
		cyc(1);
		chk(softstart_request, 1'h0);
		i_pm_side_model.set_mode(1'h1, 1'h1, 1'h0);
		i_pm_side_model.ticks(9);
		st();
		chk(s[2:0], ST_START);
		chk(phase2_drive, DRV_CCM);
		i_pm_side_model.set_mode(1'h1, 1'h0, 1'h1);
		@(posedge pclk) softstart_done <= 1'h1;
		cyc(3);
		chk(output_good_flag, 1'h1);
	endtask

	task automatic t_regs();
		logic e;
		apb(1'h1, ADDR_CTRL, 32'hffff_ffff, s, e);
		apb(1'h0, ADDR_CTRL, 32'h0, s, e);
		chk(s, 32'h1);
		apb(1'h1, ADDR_CTRL, 32'h0, s, e);
		apb(1'h0, 12'h00c, 32'h0, s, e);
		chk({s[30:0], e}, 32'h1);
	endtask

	task automatic t_shed();
		i_pm_side_model.set_mode(1'h0, 1'h0, 1'h1);
		i_pm_side_model.ticks(2);
		st();
		chk(s[2:0], ST_TWO_CCM);
		i_pm_side_model.set_ramp(1'h1);
		i_pm_side_model.ticks(2);
		st();
		chk(s[2:0], ST_TWO_CCM);
		i_pm_side_model.set_ramp(1'h0);
		st();
		chk(s[2:0], ST_SHED);
		chk({current_shift, phase2_drive}, {1'h1, DRV_CCM});
		@(posedge pclk) sense.phase2_zero <= 1'h1;
		st();
		chk(s[2:0], ST_ONE_CCM);
		chk({phase1_drive, phase2_drive}, {DRV_CCM, DRV_HIZ});
		chk(oc_half_threshold, 1'h1);
		i_pm_side_model.set_mode(1'h1, 1'h0, 1'h1);
		cyc(1); // Request passes its register before the state moves
		st();
		chk(s[2:0], ST_TWO_CCM);
		chk({oc_half_threshold, slew_fast}, 2'h1);
	endtask

	task automatic t_dcm();
		i_pm_side_model.set_mode(1'h1, 1'h1, 1'h0);
		i_pm_side_model.ticks(7);
		chk(phase1_drive == DRV_DCM, 1'h0);
		i_pm_side_model.ticks(1);
		st();
		chk(s[2:0], ST_ONE_DCM);
		chk({phase2_drive, slew_fast}, {DRV_HIZ, 1'h0});
		@(posedge pclk) sense.phase1_zero <= 1'h1;
		cyc(2);
		chk(phase1_low_off, 1'h1);
		i_pm_side_model.set_vid(7'h1d);
		cyc(2);
		chk({phase1_drive, phase2_drive}, {DRV_CCM, DRV_CCM});
		i_pm_side_model.set_mode(1'h1, 1'h0, 1'h1);
		@(posedge pclk) sense <= '0;
		@(posedge pclk) sense.thermistor_low <= 1'h1;
		cyc(3);
		chk({thermal_throttle_n, output_good_flag, phase2_drive}, {2'h1, DRV_CCM});
		@(posedge pclk) sense.thermistor_low <= 1'h0;
	endtask

	// Each timed fault: a short burst is ignored, a long one latches
	task automatic t_faults();
		int lim[4] = '{20, 40, 40, 40};
		for (int i = 0; i < 4; i++) begin
			set_flt(i, 1'h1);
			cyc(lim[i] - 4);
			set_flt(i, 1'h0);
			cyc(2);
			chk(output_good_flag, 1'h1);
			set_flt(i, 1'h1);
			cyc(lim[i] + 3);
			chk({output_good_flag, phase1_drive, phase2_drive}, {1'h0, DRV_HIZ, DRV_HIZ});
			set_flt(i, 1'h0);
			st();
			chk(s[5 + i], 1'h1);
			restart();
			st();
			chk({s[8:5], output_good_flag}, 5'h1);
		end
	endtask

	task automatic t_hard();
		@(posedge pclk) sense.oc_over_twice <= 1'h1;
		cyc(1);
		chk({output_good_flag, phase1_drive, phase2_drive}, {1'h0, DRV_HIZ, DRV_HIZ});
		@(posedge pclk) sense.oc_over_twice <= 1'h0;
		restart();
		@(posedge pclk) upstream_supplies_good <= 1'h0;
		cyc(3);
		@(posedge pclk) upstream_supplies_good <= 1'h1;
		st();
		chk({s[9], output_good_flag, phase1_drive}, {2'h2, DRV_HIZ});
		restart();
		chk(output_good_flag, 1'h1);
		repeat (2) begin
			@(posedge pclk) sense.overvolt_1v7 <= 1'h1;
			cyc(1);
			chk({output_good_flag, phase1_drive, phase2_drive}, {1'h0, DRV_LOW_ON, DRV_LOW_ON});
			@(posedge pclk) sense <= 10'h008;
			cyc(3);
			chk({phase1_drive, phase2_drive}, {DRV_HIZ, DRV_HIZ});
			@(posedge pclk) sense <= '0;
		end
		restart();
		st();
		chk({s[11], output_good_flag}, 2'h2);
		@(posedge pclk) presetn <= 1'h0;
		cyc(2);
		@(posedge pclk) presetn <= 1'h1;
		st();
		chk({s[11], output_good_flag}, 2'h1);
	endtask

	// ----------------------------------------
	// Sequence, verdict and watchdog
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'h0;
		sense = '0;
		t_start();
		t_regs();
		t_shed();
		t_dcm();
		t_faults();
		t_hard();
		print_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
